// File: hw/fopfs_pkg.sv
// Constants and types for the fail output pin function select block
package fopfs_pkg;

    // ------------------------------------------------------------
    // Clock and pattern timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 250_000_000;   // Core clock rate
    localparam int unsigned SIDE_FREQ_MHZ   = 1250;          // 1.25 Hz in milli-hertz
    localparam int unsigned SIDE_DUTY_PCT   = 50;            // Side indicator low share
    localparam int unsigned PULSE_FREQ_HZ   = 100;           // Pulsed light rate
    localparam int unsigned PULSE_DUTY_PCT  = 20;            // Pulsed light low share
    // Period counts in cycles
    localparam int unsigned SIDE_PERIOD_CYC  = (CLK_HZ / SIDE_FREQ_MHZ) * 1000;
    localparam int unsigned SIDE_LOW_CYC     = SIDE_PERIOD_CYC / 100 * SIDE_DUTY_PCT;
    localparam int unsigned PULSE_PERIOD_CYC = CLK_HZ / PULSE_FREQ_HZ;
    localparam int unsigned PULSE_LOW_CYC    = PULSE_PERIOD_CYC / 100 * PULSE_DUTY_PCT;
    // Start-up strap sampling window
    localparam int unsigned STRAP_WAIT_CYC   = 16;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;   // Fail enables and measure select
    localparam logic [7:0] ADDR_MPIN   = 8'h04;   // Multi-pin function select
    localparam logic [7:0] ADDR_STATUS = 8'h08;   // Straps and pin state

    // Control fields
    localparam int unsigned CTRL_SIDE_EN  = 0;
    localparam int unsigned CTRL_PULSE_EN = 1;
    localparam int unsigned CTRL_MEAS     = 2;
    localparam int unsigned CTRL_FAIL     = 3;
    localparam int unsigned CTRL_WAKE     = 4;
    // Multi-pin fields
    localparam int unsigned MPIN_A_LSB    = 0;
    localparam int unsigned MPIN_B_LSB    = 2;
    localparam int unsigned MPIN_A_OUT    = 4;
    localparam int unsigned MPIN_B_OUT    = 5;

    // Multi-pin function encoding
    typedef enum logic [1:0] {
        FOPFS_FN_FAIL      = 2'h0,
        FOPFS_FN_WAKE      = 2'h1,
        FOPFS_FN_LOW_SIDE  = 2'h2,
        FOPFS_FN_HIGH_SIDE = 2'h3
    } fopfs_fn_e;

    localparam logic [7:0] CTRL_RESET = 8'h00;   // All fail patterns off
    localparam logic [7:0] MPIN_RESET = 8'h00;   // Both pins in fail function

endpackage

// File: hw/fopfs_pattern.sv
// Fail pattern generator: periodic low phase for an open-drain fail pin
`timescale 1ns/1ps
module fopfs_pattern #(
    parameter int unsigned PERIOD_CYC = 200,   // Whole period in cycles
    parameter int unsigned LOW_CYC    = 100    // Asserted (low) cycles
) (
    input  wire logic i_clk,         // Core clock
    input  wire logic i_reset_n,     // Synchronous reset, active low
    input  wire logic i_enable,      // Pattern running
    output logic      o_assert       // High during the low phase
);
    localparam int unsigned CW = $clog2(PERIOD_CYC);

    logic [CW-1:0] cnt_ff;           // Position within the period

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    // Restart on disable so every activation begins with a full low phase
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_enable) begin
            cnt_ff <= '0;
        end else if (cnt_ff == CW'(PERIOD_CYC - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // Asserted phase first, then released
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_assert <= 1'b0;
        end else begin
            o_assert <= i_enable && (cnt_ff < CW'(LOW_CYC));
        end
    end
endmodule

// File: hw/fopfs_top.sv
// Multi-function pin logic: interrupt line, fail patterns, straps, wake measure
`timescale 1ns/1ps

// Overview of operation
// - Drive interrupt low on failure, or on wake in stop or normal mode
// - Sample interrupt pull-up at start-up for configuration
// - Side indicator pattern 1.25 Hz, 50 percent
// - Pulsed light pattern 100 Hz, 20 percent
// - Test pin low at power-up enters development
// - Fail pins reconfigurable as wake, low, high side
// - Fail pins default to fail function after reset
// - Measure bit moves wake pins to measurement
// - Wake pin a is input, b output
module fopfs_top #(
    // Pattern timing in cycles
    parameter int unsigned SIDE_PERIOD  = fopfs_pkg::SIDE_PERIOD_CYC,
    parameter int unsigned SIDE_LOW     = fopfs_pkg::SIDE_LOW_CYC,
    parameter int unsigned PULSE_PERIOD = fopfs_pkg::PULSE_PERIOD_CYC,
    parameter int unsigned PULSE_LOW    = fopfs_pkg::PULSE_LOW_CYC
) (
    input  wire logic        i_clk,                   // Core clock, 250 MHz
    input  wire logic        i_reset_n,               // Synchronous power-on reset

    // Register port
    input  wire logic [7:0]  i_addr,                  // Byte address
    input  wire logic [31:0] i_wdata,                 // Write data
    input  wire logic        i_wr,                    // Write strobe
    input  wire logic        i_rd,                    // Read strobe
    output logic      [31:0] o_rdata,                 // Read data, one cycle later

    // Events
    input  wire logic        i_wake_event,            // Wake-up event pulse
    input  wire logic        i_fail_event,            // Failure event pulse
    input  wire logic        i_run_mode,              // Stop or normal mode active

    // Interrupt line, open drain
    input  wire logic        i_int_n_in,              // Pin level
    output logic             o_int_n_out,             // Always drives low
    output logic             o_int_n_oe,              // Pulls the line low

    // Test strap
    input  wire logic        i_test_n_in,             // Test pin level
    output logic             o_dev_mode,              // Development mode latched
    output logic             o_config_pullup,         // Config 1/3 when high

    // Side indicator pin / multi pin a
    input  wire logic        i_multi_pin_a_in,        // Pin level
    output logic             o_side_indicator_fail_out, // Pin drive value
    output logic             o_multi_pin_a_oe,        // Pin drive enable
    output logic             o_multi_pin_a_hs,        // High-side switch on
    output logic             o_multi_pin_a_wake,      // Wake level when wake input

    // Pulsed light pin / multi pin b
    input  wire logic        i_multi_pin_b_in,        // Pin level
    output logic             o_pulsed_light_fail_out, // Pin drive value
    output logic             o_multi_pin_b_oe,        // Pin drive enable
    output logic             o_multi_pin_b_hs,        // High-side switch on
    output logic             o_multi_pin_b_wake,      // Wake level when wake input

    // High voltage wake pins
    output logic             o_hv_measure_select,     // Measurement path enabled
    output logic             o_hv_wake_in_a_meas_in,  // Pin a used as measure input
    output logic             o_hv_wake_in_b_meas_out  // Pin b used as measure output
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software visible words
    logic [7:0] ctrl_ff;             // Pattern enables, measure, two spare bits
    logic [7:0] mpin_ff;             // Multi-pin functions and output levels

    // Interrupt request
    logic       int_pend_ff;         // Interrupt request sticky

    // Five bits hold the window
    logic [4:0] strap_cnt_ff;        // Start-up strap window
    logic       strap_done_ff;       // Straps captured

    // Generator phases
    logic       side_on;             // Side pattern low phase
    logic       pulse_on;            // Pulsed pattern low phase

    // Decoded pin functions
    fopfs_pkg::fopfs_fn_e fn_a;      // Function of pin a
    fopfs_pkg::fopfs_fn_e fn_b;      // Function of pin b

    // Two-bit fields of the pin word
    assign fn_a = fopfs_pkg::fopfs_fn_e'(mpin_ff[fopfs_pkg::MPIN_A_LSB +: 2]);
    assign fn_b = fopfs_pkg::fopfs_fn_e'(mpin_ff[fopfs_pkg::MPIN_B_LSB +: 2]);

    // Drive decision for one multi pin: 1 means pull low actively
    // Wake and high side never pull low
    // Low side follows its level bit
    function automatic logic pin_low(input fopfs_pkg::fopfs_fn_e fn,
                                     input logic pattern,
                                     input logic level);
        unique case (fn)
            fopfs_pkg::FOPFS_FN_FAIL:      pin_low = pattern;
            fopfs_pkg::FOPFS_FN_WAKE:      pin_low = 1'b0;
            fopfs_pkg::FOPFS_FN_LOW_SIDE:  pin_low = level;
            fopfs_pkg::FOPFS_FN_HIGH_SIDE: pin_low = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Spare control bits only stored
    // Upper write bits are dropped
    // reset to fail function
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_ff <= fopfs_pkg::CTRL_RESET;
            mpin_ff <= fopfs_pkg::MPIN_RESET;
        end else if (i_wr) begin
            if (i_addr == fopfs_pkg::ADDR_CTRL) begin
                ctrl_ff <= {3'h0, i_wdata[4:0]};
            end
            // Pin function word
            if (i_addr == fopfs_pkg::ADDR_MPIN) begin
                mpin_ff <= {2'h0, i_wdata[5:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------
    // A request meeting the clearing
    // read is kept, none is lost
    // sticky request, set wins over clear
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            int_pend_ff <= 1'b0;
        end else if ((i_wake_event && i_run_mode) || i_fail_event) begin
            // Wake counts in stop or normal only
            int_pend_ff <= 1'b1;
        end else if (i_rd && i_addr == fopfs_pkg::ADDR_STATUS) begin
            // Status read acknowledges the request
            int_pend_ff <= 1'b0;
        end
    end

    // Open drain: enable sets the level
    // Held released until straps are sampled so the pull-up reads true
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_int_n_out <= 1'b0;
            o_int_n_oe  <= 1'b0;
        end else begin
            // Value fixed low, enable toggles
            o_int_n_out <= 1'b0;
            o_int_n_oe  <= strap_done_ff && int_pend_ff;
        end
    end

    // ------------------------------------------------------------
    // Start-up straps
    // ------------------------------------------------------------
    // Window lets the pull-up settle
    // Levels frozen until next reset
    // Captured by a clocked process after release, never by reset itself
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            // Straps read zero until taken
            strap_cnt_ff    <= '0;
            strap_done_ff   <= 1'b0;
            o_dev_mode      <= 1'b0;
            o_config_pullup <= 1'b0;
        end else if (!strap_done_ff) begin
            if (strap_cnt_ff == 5'(fopfs_pkg::STRAP_WAIT_CYC - 1)) begin
                strap_done_ff   <= 1'b1;
                o_config_pullup <= i_int_n_in;
                o_dev_mode      <= !i_test_n_in;
            end
            // Stops with the window, no wrap
            strap_cnt_ff <= strap_cnt_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Fail patterns
    // ------------------------------------------------------------
    // Runs only in fail function, so a
    // reassigned pin never shows it
    // side indicator timing
    fopfs_pattern #(
        .PERIOD_CYC (SIDE_PERIOD),
        .LOW_CYC    (SIDE_LOW)
    ) u_side (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_enable  (ctrl_ff[fopfs_pkg::CTRL_SIDE_EN] && fn_a == fopfs_pkg::FOPFS_FN_FAIL),
        .o_assert  (side_on)
    );

    // Same generator, brake lamp timing
    // pulsed light timing
    fopfs_pattern #(
        .PERIOD_CYC (PULSE_PERIOD),
        .LOW_CYC    (PULSE_LOW)
    ) u_pulse (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_enable  (ctrl_ff[fopfs_pkg::CTRL_PULSE_EN] && fn_b == fopfs_pkg::FOPFS_FN_FAIL),
        .o_assert  (pulse_on)
    );

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // High side outputs are plain levels
    // Open drain: value always low, enable in the asserted phase, or from the level bit in low side
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_side_indicator_fail_out <= 1'b0;
            o_pulsed_light_fail_out   <= 1'b0;
            o_multi_pin_a_oe          <= 1'b0;
            o_multi_pin_b_oe          <= 1'b0;
            o_multi_pin_a_hs          <= 1'b0;
            o_multi_pin_b_hs          <= 1'b0;
        end else begin
            // A high level is never driven
            o_side_indicator_fail_out <= 1'b0;
            o_pulsed_light_fail_out   <= 1'b0;

            // Low side: level bit one pulls low
            // released outside low phase
            o_multi_pin_a_oe <= pin_low(fn_a, side_on, mpin_ff[fopfs_pkg::MPIN_A_OUT]);
            o_multi_pin_b_oe <= pin_low(fn_b, pulse_on, mpin_ff[fopfs_pkg::MPIN_B_OUT]);
            o_multi_pin_a_hs <= (fn_a == fopfs_pkg::FOPFS_FN_HIGH_SIDE)
                                && mpin_ff[fopfs_pkg::MPIN_A_OUT];
            o_multi_pin_b_hs <= (fn_b == fopfs_pkg::FOPFS_FN_HIGH_SIDE)
                                && mpin_ff[fopfs_pkg::MPIN_B_OUT];
        end
    end

    // Pin level passed through one flop
    // Wake input levels, only meaningful in wake function
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_multi_pin_a_wake <= 1'b0;
            o_multi_pin_b_wake <= 1'b0;
        end else begin
            o_multi_pin_a_wake <= (fn_a == fopfs_pkg::FOPFS_FN_WAKE) && i_multi_pin_a_in;
            o_multi_pin_b_wake <= (fn_b == fopfs_pkg::FOPFS_FN_WAKE) && i_multi_pin_b_in;
        end
    end

    // ------------------------------------------------------------
    // High voltage measurement
    // ------------------------------------------------------------
    // Three outputs spare the switch
    // stage any decoding
    // Both pins switch together; one alone is never in measure use
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_hv_measure_select     <= 1'b0;
            o_hv_wake_in_a_meas_in  <= 1'b0;
            o_hv_wake_in_b_meas_out <= 1'b0;
        end else begin
            o_hv_measure_select     <= ctrl_ff[fopfs_pkg::CTRL_MEAS];
            // Both roles follow the same bit
            // a input, b output
            o_hv_wake_in_a_meas_in  <= ctrl_ff[fopfs_pkg::CTRL_MEAS];
            o_hv_wake_in_b_meas_out <= ctrl_ff[fopfs_pkg::CTRL_MEAS];
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Data stand one cycle, then zero
    // Status: straps, pending, pins
    // Unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                fopfs_pkg::ADDR_CTRL:   o_rdata <= {24'h00_0000, ctrl_ff};
                fopfs_pkg::ADDR_MPIN:   o_rdata <= {24'h00_0000, mpin_ff};
                fopfs_pkg::ADDR_STATUS: o_rdata <= {24'h00_0000, pulse_on, side_on,
                                                    i_multi_pin_b_in, i_multi_pin_a_in,
                                                    int_pend_ff, strap_done_ff,
                                                    o_config_pullup, o_dev_mode};
                default:                o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule

// File: tb/fopfs_top_chk.sv
// Port checker for the multi-function pin block
`timescale 1ns/1ps
module fopfs_top_chk #(
    parameter int unsigned SIDE_LOW  = 5,
    parameter int unsigned PULSE_LOW = 2
) (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_fail_event,
    input wire logic        i_int_n_in,
    input wire logic        i_test_n_in,
    input wire logic        o_int_n_oe,
    input wire logic        o_dev_mode,
    input wire logic        o_config_pullup,
    input wire logic        o_multi_pin_a_oe,
    input wire logic        o_multi_pin_a_hs,
    input wire logic        o_multi_pin_b_oe,
    input wire logic        o_multi_pin_b_hs,
    input wire logic        o_hv_measure_select,
    input wire logic        o_hv_wake_in_a_meas_in,
    input wire logic        o_hv_wake_in_b_meas_out
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic [4:0]  rel_ff;            // Edges since release, saturating
    logic [4:0]  ctrl_ff;           // Shadow of the control word
    logic [5:0]  mpin_ff;           // Shadow of the pin function word
    int unsigned run_a_ff, run_b_ff; // Length of the current low phase
    logic        st_rd;             // Status read, clears the pending flag
    logic        side_act, pulse_act; // Pattern enabled on a fail pin

    assign st_rd     = i_rd && i_addr == fopfs_pkg::ADDR_STATUS;
    assign side_act  = ctrl_ff[0] && mpin_ff[1:0] == 2'h0;
    assign pulse_act = ctrl_ff[1] && mpin_ff[3:2] == 2'h0;

    // Strap timing reference
    always_ff @(posedge i_clk) begin
        rel_ff <= !i_reset_n ? 5'h0 : rel_ff + {4'h0, rel_ff != 5'h1f};
    end
    // Shadow registers, upper bits dropped as the block does
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_ff <= 5'h0;
            mpin_ff <= 6'h0;
        end else if (i_wr && i_addr == fopfs_pkg::ADDR_CTRL) begin
            ctrl_ff <= i_wdata[4:0];
        end else if (i_wr && i_addr == fopfs_pkg::ADDR_MPIN) begin
            mpin_ff <= i_wdata[5:0];
        end
    end
    // Run lengths; counting from the output avoids modelling the generator
    always_ff @(posedge i_clk) begin
        run_a_ff <= (i_reset_n && o_multi_pin_a_oe) ? run_a_ff + 1 : 0;
        run_b_ff <= (i_reset_n && o_multi_pin_b_oe) ? run_b_ff + 1 : 0;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    meas_path_a: assert property (o_hv_measure_select == $past(ctrl_ff[2])
        && o_hv_wake_in_a_meas_in == o_hv_measure_select
        && o_hv_wake_in_b_meas_out == o_hv_measure_select) else $error("measure path");
    fail_int_a: assert property (rel_ff == 5'h1f && i_fail_event |-> ##2 o_int_n_oe)
        else $error("failure not flagged");
    int_hold_a: assert property (o_int_n_oe && !st_rd && !$past(st_rd) |=> o_int_n_oe)
        else $error("interrupt dropped");
    strap_val_a: assert property (rel_ff == 5'd20 |-> o_dev_mode == !i_test_n_in
        && o_config_pullup == i_int_n_in) else $error("strap value");
    strap_wait_a: assert property (rel_ff < 5'd15 |-> !o_dev_mode && !o_config_pullup)
        else $error("strap early");
    side_low_a: assert property ($fell(o_multi_pin_a_oe) && $past(side_act, 2)
        |-> run_a_ff == SIDE_LOW) else $error("side low phase");
    pulse_low_a: assert property ($fell(o_multi_pin_b_oe) && $past(pulse_act, 2)
        |-> run_b_ff == PULSE_LOW) else $error("pulse low phase");
    hs_map_a: assert property ($past(mpin_ff[1:0]) == 2'h3 && $past(mpin_ff[4])
        |-> o_multi_pin_a_hs && !o_multi_pin_a_oe) else $error("high side map");
    ls_map_a: assert property ($past(mpin_ff[3:2]) == 2'h2
        |-> o_multi_pin_b_oe == $past(mpin_ff[5]) && !o_multi_pin_b_hs) else $error("low side map");

    cover property ($fell(o_multi_pin_a_oe));
    cover property ($rose(o_int_n_oe));
    cover property ($rose(o_hv_measure_select));
endmodule
bind fopfs_top fopfs_top_chk #(.SIDE_LOW(SIDE_LOW), .PULSE_LOW(PULSE_LOW)) u_fopfs_top_chk (
    .i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_fail_event, .i_int_n_in,
    .i_test_n_in, .o_int_n_oe, .o_dev_mode, .o_config_pullup, .o_multi_pin_a_oe,
    .o_multi_pin_a_hs, .o_multi_pin_b_oe, .o_multi_pin_b_hs, .o_hv_measure_select,
    .o_hv_wake_in_a_meas_in, .o_hv_wake_in_b_meas_out);

// File: tb/fopfs_board.sv
// Board model: strap resistors and lamp loads on the shared pins
`timescale 1ns/1ps
module fopfs_board (
    input  wire logic int_pullup,        // External pull-up fitted on the line
    input  wire logic test_gnd,          // Test pin strapped to ground
    input  wire logic o_int_n_oe,        // Device pulls the line low
    input  wire logic o_multi_pin_a_oe,  // Device pulls pin a low
    input  wire logic o_multi_pin_b_oe,  // Device pulls pin b low
    output logic      i_int_n_in,        // Resolved line level
    output logic      i_test_n_in,       // Resolved test pin level
    output logic      i_multi_pin_a_in,  // Resolved pin a level
    output logic      i_multi_pin_b_in   // Resolved pin b level
);
    // released line settles to the strap; weak internal pull-down otherwise
    assign i_int_n_in       = o_int_n_oe ? 1'b0 : int_pullup;
    // internal pull-up unless tied to ground
    assign i_test_n_in      = !test_gnd;
    // lamp load lifts a released pin
    assign i_multi_pin_a_in = !o_multi_pin_a_oe;
    assign i_multi_pin_b_in = !o_multi_pin_b_oe;
endmodule

// File: tb/test_fopfs_top.sv
// Self-checking bench for the multi-function pin block
`timescale 1ns/1ps
module test_fopfs_top;
    logic        i_clk, i_reset_n, i_wr, i_rd, i_wake_event, i_fail_event, i_run_mode;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, rd_data;
    logic        i_int_n_in, o_int_n_out, o_int_n_oe, i_test_n_in, o_dev_mode, o_config_pullup;
    logic        i_multi_pin_a_in, o_side_indicator_fail_out, o_multi_pin_a_oe;
    logic        o_multi_pin_a_hs, o_multi_pin_a_wake, i_multi_pin_b_in, o_pulsed_light_fail_out;
    logic        o_multi_pin_b_oe, o_multi_pin_b_hs, o_multi_pin_b_wake, o_hv_measure_select;
    logic        o_hv_wake_in_a_meas_in, o_hv_wake_in_b_meas_out, int_pullup, test_gnd;
    int          fail_count = 0, check_count = 0, cyc = 0, na, nb, k;

    // Short pattern periods keep the run brief
    fopfs_top #(.SIDE_PERIOD(10), .SIDE_LOW(5), .PULSE_PERIOD(10), .PULSE_LOW(2))
        u_fopfs_top (.*);
    fopfs_board u_fopfs_board (.*);

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Wait, then step past the edge so its updates have landed
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask
    // One-cycle event pulse with the mode level held around it
    task automatic ev(input logic f, input logic w, input logic r);
        @(posedge i_clk);
        i_fail_event <= f;
        i_wake_event <= w;
        i_run_mode   <= r;
        @(posedge i_clk);
        i_fail_event <= 1'b0;
        i_wake_event <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {i_reset_n, i_wr, i_rd, i_wake_event, i_fail_event, i_run_mode} <= 6'h0;
        {i_addr, i_wdata, int_pullup, test_gnd} <= 42'h0;
        // Two power-ups with opposite straps
        for (k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_reset_n  <= 1'b0;
            int_pullup <= k[0];
            test_gnd   <= !k[0];
            repeat (12) @(posedge i_clk);
            i_reset_n  <= 1'b1;
            cycles(24);
            chk("dev_mode", {31'h0, !k[0]}, {31'h0, o_dev_mode});
            chk("config", {31'h0, k[0]}, {31'h0, o_config_pullup});
            rd(fopfs_pkg::ADDR_STATUS, rd_data);
            chk("status", 32'h35 + k, rd_data);
            rd(fopfs_pkg::ADDR_MPIN, rd_data);
            chk("mpin_reset", 32'h0, rd_data);
        end
        rd(8'h0c, rd_data);
        chk("unmapped", 32'h0, rd_data);
        // Wake outside run mode, wake in run mode, failure
        for (k = 0; k < 3; k++) begin
            ev(k == 2, k < 2, k == 1);
            cycles(2);
            chk("int_oe", {31'h0, k != 0}, {31'h0, o_int_n_oe});
            chk("int_line", {31'h0, k == 0}, {31'h0, i_int_n_in});
            rd(fopfs_pkg::ADDR_STATUS, rd_data);
            chk("int_pend", {31'h0, k != 0}, {31'h0, rd_data[3]});
            cycles(2);
            chk("int_clear", 32'h0, {31'h0, o_int_n_oe});
        end
        // Measure bit drives all three measure outputs; upper control bits dropped
        wr(fopfs_pkg::ADDR_CTRL, 32'h4);
        cycles(2);
        chk("meas", 32'h7, {29'h0, o_hv_measure_select, o_hv_wake_in_a_meas_in,
            o_hv_wake_in_b_meas_out});
        wr(fopfs_pkg::ADDR_CTRL, 32'hffffffe0);
        rd(fopfs_pkg::ADDR_CTRL, rd_data);
        chk("ctrl_upper", 32'h0, rd_data);
        chk("meas_off", 32'h0, {31'h0, o_hv_measure_select});
        // Whole periods in a window give exact low counts
        wr(fopfs_pkg::ADDR_CTRL, 32'h3);
        cycles(5);
        na = 0;
        nb = 0;
        repeat (40) begin
            cycles(1);
            na += int'(o_multi_pin_a_oe);
            nb += int'(o_multi_pin_b_oe);
        end
        chk("side_low", 32'd20, na);
        chk("pulse_low", 32'd8, nb);
        wr(fopfs_pkg::ADDR_CTRL, 32'h0);
        cycles(2);
        chk("released", 32'h0, {30'h0, o_multi_pin_a_oe, o_multi_pin_b_oe});
        chk("od_value", 32'h0, {29'h0, o_int_n_out, o_side_indicator_fail_out,
            o_pulsed_light_fail_out});
        // Wake, low-side, high-side; patterns enabled yet absent
        for (k = 1; k < 4; k++) begin
            wr(fopfs_pkg::ADDR_MPIN, 32'(32'h30 | (k << 2) | k));
            wr(fopfs_pkg::ADDR_CTRL, 32'h3);
            cycles(3);
            chk("pin_a", {29'h0, k == 3, k == 2, k == 1}, {29'h0, o_multi_pin_a_hs,
                o_multi_pin_a_oe, o_multi_pin_a_wake});
            chk("pin_b", {29'h0, k == 3, k == 2, k == 1}, {29'h0, o_multi_pin_b_hs,
                o_multi_pin_b_oe, o_multi_pin_b_wake});
        end
        wr(fopfs_pkg::ADDR_CTRL, 32'h0);
        wr(fopfs_pkg::ADDR_MPIN, 32'h0);
        cycles(3);
        end_of_test();
    end
endmodule
